// ---- core/qtab_pkg.sv ----
// Constants shared by both ends of the query burst capability table link
package qtab_pkg;
    // Link widths
    localparam int QT_AW = 9;
    localparam int QT_DW = 16;

    // Query locations
    localparam logic [8:0] QT_ADDR_WIDTH = 9'h028;
    localparam logic [8:0] QT_ADDR_PAGE  = 9'h127;
    localparam logic [8:0] QT_ADDR_NSYNC = 9'h128;
    localparam logic [8:0] QT_ADDR_SYNC0 = 9'h129;
    localparam logic [8:0] QT_ADDR_SYNC3 = 9'h12C;
    localparam logic [8:0] QT_ADDR_NPART = 9'h12D;
    localparam logic [8:0] QT_ADDR_END   = 9'h1FF;

    // Table contents
    localparam logic [7:0]  QT_PAGE_CODE  = 8'h03;
    localparam logic [7:0]  QT_NSYNC      = 8'h04;
    localparam logic [31:0] QT_SYNC_CODES = 32'h0703_0201;
    localparam logic [7:0]  QT_WIDTH_X16  = 8'h01;
    localparam logic [7:0]  QT_NPART      = 8'h01;
    localparam logic [7:0]  QT_NONE       = 8'h00;

    // Burst encodings and sizes
    localparam int         QT_NSYNC_MAX  = 4;
    localparam int         QT_SYNC_BITS  = 3;
    localparam logic [2:0] QT_BURST_CONT = 3'h7;
    localparam logic [8:0] QT_LEN_ONE    = 9'h001;

    // Host discovery steps
    localparam logic [3:0] QT_STEP_WIDTH = 4'h0;
    localparam logic [3:0] QT_STEP_PAGE  = 4'h1;
    localparam logic [3:0] QT_STEP_NSYNC = 4'h2;
    localparam logic [3:0] QT_STEP_SYNC0 = 4'h3;
    localparam logic [3:0] QT_STEP_NPART = 4'h7;
endpackage

// ---- core/qtab_if.sv ----
// Link between the query table device end and the reading host end
`timescale 1ns/10ps
interface qtab_if;
    import qtab_pkg::*;
    logic              req;
    logic [QT_AW-1:0]  addr;
    logic              burst;
    logic [2:0]        bcode;
    logic              busy;
    logic              dvalid;
    logic [QT_DW-1:0]  data;
    logic              dlast;

    modport dev (
        input  req, addr, burst, bcode,
        output busy, dvalid, data, dlast
    );
    modport host (
        output req, addr, burst, bcode,
        input  busy, dvalid, data, dlast
    );
endinterface

// ---- core/qtab_dev.sv ----
// Device end: serves the burst capability query entries over the link
`timescale 1ns/10ps
module qtab_dev
    import qtab_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Link to host
    qtab_if.dev       lnk
);

    typedef enum logic {QD_IDLE, QD_SEND} qtab_dstate_type;

    qtab_dstate_type   state_reg;
    logic [QT_AW-1:0]  addr_reg;
    logic [8:0]        cnt_reg;
    logic              cont_reg;
    logic              busy_reg;
    logic              dvalid_reg;
    logic              dlast_reg;
    logic [QT_DW-1:0]  data_reg;

    logic              take;
    logic              end_now;
    logic [8:0]        len_next;
    logic [QT_DW-1:0]  entry;

    // Table lookup; the table is constant so a read never alters it
    function automatic logic [QT_DW-1:0] qt_lookup(input logic [QT_AW-1:0] a);
        logic [7:0] b;
        logic [1:0] idx;
        b   = QT_NONE;
        idx = 2'(a - QT_ADDR_SYNC0);
        if (a == QT_ADDR_WIDTH) begin
            b = QT_WIDTH_X16;
        end else if (a == QT_ADDR_PAGE) begin
            b = QT_PAGE_CODE;
        end else if (a == QT_ADDR_NSYNC) begin
            b = QT_NSYNC;
        end else if (a >= QT_ADDR_SYNC0 && a <= QT_ADDR_SYNC3) begin
            b = QT_SYNC_CODES[idx*8 +: 8];
        end else if (a == QT_ADDR_NPART) begin
            b = QT_NPART;
        end
        return {8'h00, b};
    endfunction

    assign entry   = qt_lookup(addr_reg);
    assign take    = (state_reg == QD_IDLE) && lnk.req;
    // Every burst also stops at the end of the burstable space
    assign end_now = (addr_reg == QT_ADDR_END) || (!cont_reg && cnt_reg == QT_LEN_ONE);

    // Burst length 2^(n+1) words; code 07h runs until end of space
    always_comb begin
        len_next = QT_LEN_ONE;
        if (lnk.burst && lnk.bcode != QT_BURST_CONT) begin
            len_next = 9'(QT_LEN_ONE << (lnk.bcode + 3'h1));
        end
    end

    // Transfer sequencing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= QD_IDLE;
        end else begin
            case (state_reg)
                QD_IDLE: begin
                    if (take) begin
                        state_reg <= QD_SEND;
                    end
                end
                QD_SEND: begin
                    if (end_now) begin
                        state_reg <= QD_IDLE;
                    end
                end
                default: begin
                    state_reg <= QD_IDLE;
                end
            endcase
        end
    end

    // Address and word counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_reg <= '0;
            cnt_reg  <= '0;
            cont_reg <= 1'b0;
        end else if (take) begin
            addr_reg <= lnk.addr;
            cnt_reg  <= len_next;
            cont_reg <= lnk.burst && (lnk.bcode == QT_BURST_CONT);
        end else if (state_reg == QD_SEND && !end_now) begin
            addr_reg <= addr_reg + 9'h001;
            cnt_reg  <= cnt_reg - 9'h001;
        end
    end

    // Busy covers the whole transfer; it falls with the last word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else if (take) begin
            busy_reg <= 1'b1;
        end else if (state_reg == QD_SEND && end_now) begin
            busy_reg <= 1'b0;
        end
    end

    // Data output path
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dvalid_reg <= 1'b0;
            dlast_reg  <= 1'b0;
            data_reg   <= '0;
        end else if (state_reg == QD_SEND) begin
            dvalid_reg <= 1'b1;
            dlast_reg  <= end_now;
            data_reg   <= entry;
        end else begin
            dvalid_reg <= 1'b0;
            dlast_reg  <= 1'b0;
            data_reg   <= '0;
        end
    end

    assign lnk.busy   = busy_reg;
    assign lnk.dvalid = dvalid_reg;
    assign lnk.dlast  = dlast_reg;
    assign lnk.data   = data_reg;

endmodule // qtab_dev

// ---- core/qtab_host.sv ----
// Host end: discovers page and burst settings from the query table
`timescale 1ns/10ps
module qtab_host
    import qtab_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Link to device
    qtab_if.host                   lnk,
    // Discovery control
    input  wire logic              disc_start,
    input  wire logic [1:0]        sync_sel,
    output logic                   disc_done,
    output logic                   page_ok,
    output logic [7:0]             page_code,
    output logic [7:0]             data_width,
    output logic                   burst_ok,
    output logic [2:0]             rcr_burst,
    output logic                   rcr_valid,
    output logic                   single_part,
    output logic [7:0]             part_count,
    // User reads
    input  wire logic              rd_start,
    input  wire logic [QT_AW-1:0]  rd_addr,
    input  wire logic              rd_burst,
    output logic                   rd_valid,
    output logic [QT_DW-1:0]       rd_data,
    output logic                   rd_last
);

    typedef enum logic [1:0] {QH_IDLE, QH_ISSUE, QH_WAIT} qtab_hstate_type;

    qtab_hstate_type   state_reg;
    logic              disc_reg;
    logic [3:0]        step_reg;
    logic              req_reg;
    logic [QT_AW-1:0]  addr_reg;
    logic              burst_reg;
    logic [2:0]        bcode_reg;
    logic              done_reg;
    logic [7:0]        width_reg;
    logic [7:0]        page_reg;
    logic [7:0]        nsync_reg;
    logic [7:0]        npart_reg;
    logic [2:0]        sync_code_reg [QT_NSYNC_MAX];
    logic [2:0]        rcr_reg;
    logic              rcr_valid_reg;
    logic              rd_valid_reg;
    logic              rd_last_reg;
    logic [QT_DW-1:0]  rd_data_reg;

    logic [3:0]        step_next;
    logic [QT_AW-1:0]  step_addr;
    logic              got;

    assign got = (state_reg == QH_WAIT) && lnk.dvalid;

    // Step after the current one; sync steps beyond the count are skipped
    always_comb begin
        step_next = step_reg + 4'h1;
        // The count is still on the link here; nsync_reg only takes it on this same edge
        if (step_reg == QT_STEP_NSYNC && lnk.data[7:0] == QT_NONE) begin
            step_next = QT_STEP_NPART;
        end else if (step_reg >= QT_STEP_SYNC0 && step_reg < QT_STEP_NPART
                     && 8'(step_reg - QT_STEP_SYNC0 + 4'h1) >= nsync_reg) begin
            step_next = QT_STEP_NPART;
        end
    end

    always_comb begin
        case (step_reg)
            QT_STEP_WIDTH: step_addr = QT_ADDR_WIDTH;
            QT_STEP_PAGE:  step_addr = QT_ADDR_PAGE;
            QT_STEP_NSYNC: step_addr = QT_ADDR_NSYNC;
            QT_STEP_NPART: step_addr = QT_ADDR_NPART;
            default:       step_addr = QT_ADDR_SYNC0 + 9'(step_reg - QT_STEP_SYNC0);
        endcase
    end

    // Request sequencing: one request at a time, next only after the last word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= QH_IDLE;
            disc_reg  <= 1'b0;
            step_reg  <= QT_STEP_WIDTH;
            req_reg   <= 1'b0;
            addr_reg  <= '0;
            burst_reg <= 1'b0;
            bcode_reg <= '0;
            done_reg  <= 1'b0;
        end else begin
            req_reg <= 1'b0;
            case (state_reg)
                QH_IDLE: begin
                    if (disc_start) begin
                        disc_reg  <= 1'b1;
                        done_reg  <= 1'b0;
                        step_reg  <= QT_STEP_WIDTH;
                        addr_reg  <= QT_ADDR_WIDTH;
                        burst_reg <= 1'b0;
                        state_reg <= QH_ISSUE;
                    end else if (rd_start && done_reg) begin
                        disc_reg  <= 1'b0;
                        addr_reg  <= rd_addr;
                        burst_reg <= rd_burst && burst_ok && rcr_valid_reg;
                        bcode_reg <= rcr_reg;
                        state_reg <= QH_ISSUE;
                    end
                end
                QH_ISSUE: begin
                    if (!lnk.busy) begin
                        req_reg   <= 1'b1;
                        state_reg <= QH_WAIT;
                    end
                end
                QH_WAIT: begin
                    if (got && lnk.dlast) begin
                        if (disc_reg && step_reg != QT_STEP_NPART) begin
                            step_reg  <= step_next;
                            state_reg <= QH_ISSUE;
                        end else begin
                            done_reg  <= done_reg || disc_reg;
                            state_reg <= QH_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= QH_IDLE;
                end
            endcase
            // Address of the step being issued goes out with the request pulse
            if (state_reg == QH_ISSUE && disc_reg) begin
                addr_reg <= step_addr;
            end
        end
    end

    // Discovery captures; only the low byte carries the entry
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            width_reg <= '0;
            page_reg  <= '0;
            nsync_reg <= '0;
            npart_reg <= '0;
        end else if (got && disc_reg) begin
            case (step_reg)
                QT_STEP_WIDTH: width_reg <= lnk.data[7:0];
                QT_STEP_PAGE:  page_reg  <= lnk.data[7:0];
                QT_STEP_NSYNC: nsync_reg <= lnk.data[7:0];
                QT_STEP_NPART: npart_reg <= lnk.data[7:0];
                default:       npart_reg <= npart_reg;
            endcase
        end
    end

    // One capture slot per sync entry; reserved bits 3-7 are dropped
    for (genvar i = 0; i < QT_NSYNC_MAX; i++) begin : g_sync
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                sync_code_reg[i] <= '0;
            end else if (got && disc_reg && step_reg == 4'(QT_STEP_SYNC0 + i)) begin
                sync_code_reg[i] <= lnk.data[QT_SYNC_BITS-1:0];
            end
        end
    end

    // Config code is applied as-is only at the maximum word width
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rcr_reg       <= '0;
            rcr_valid_reg <= 1'b0;
        end else begin
            rcr_reg       <= sync_code_reg[sync_sel];
            rcr_valid_reg <= done_reg && (width_reg == QT_WIDTH_X16)
                             && (8'(sync_sel) < nsync_reg);
        end
    end

    // User read data forwarding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid_reg <= 1'b0;
            rd_last_reg  <= 1'b0;
            rd_data_reg  <= '0;
        end else begin
            rd_valid_reg <= got && !disc_reg;
            rd_last_reg  <= got && !disc_reg && lnk.dlast;
            rd_data_reg  <= lnk.data;
        end
    end

    assign lnk.req     = req_reg;
    assign lnk.addr    = addr_reg;
    assign lnk.burst   = burst_reg;
    assign lnk.bcode   = bcode_reg;
    assign disc_done   = done_reg;
    assign page_ok     = done_reg && (page_reg != QT_NONE);
    assign page_code   = page_reg;
    assign data_width  = width_reg;
    assign burst_ok    = done_reg && (nsync_reg != QT_NONE);
    assign rcr_burst   = rcr_reg;
    assign rcr_valid   = rcr_valid_reg;
    assign single_part = done_reg && (npart_reg == QT_NONE);
    assign part_count  = npart_reg;
    assign rd_valid    = rd_valid_reg;
    assign rd_last     = rd_last_reg;
    assign rd_data     = rd_data_reg;

endmodule // qtab_host

// ---- test/qtab_properties.sv ----
// Link assertions between the query table device and host ends
`timescale 1ns/10ps
module qtab_properties
    import qtab_pkg::*;
(
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst_b,
    // Host request
    input wire logic             req,
    input wire logic [QT_AW-1:0] addr,
    input wire logic             burst,
    input wire logic [2:0]       bcode,
    // Device answer
    input wire logic             busy,
    input wire logic             dvalid,
    input wire logic [QT_DW-1:0] data,
    input wire logic             dlast
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic single_req;
    logic burst_req;
    assign single_req = req && !busy && !burst;
    assign burst_req  = req && !busy && burst;

    a_page_entry: assert property (single_req && addr == 9'h127 |-> ##2
        dvalid && dlast && data == 16'h0003) else $error("page code entry wrong");
    a_sync_count: assert property (single_req && addr == 9'h128 |-> ##2
        dvalid && data == 16'h0004) else $error("sync count entry wrong");
    a_sync_first: assert property (single_req && addr inside {9'h129, 9'h12A} |-> ##2
        data == ($past(addr, 2) == 9'h129 ? 16'h0001 : 16'h0002))
        else $error("first sync entries wrong");
    a_sync_last: assert property (single_req && addr inside {9'h12B, 9'h12C} |-> ##2
        data == ($past(addr, 2) == 9'h12B ? 16'h0003 : 16'h0007))
        else $error("last sync entries wrong");
    a_part_count: assert property (single_req && addr == 9'h12D |-> ##2
        dvalid && data == 16'h0001) else $error("partition count wrong");
    a_high_byte: assert property (data[15:8] == 8'h00 && (dvalid || data == 16'h0000))
        else $error("upper byte or idle data not zero");
    a_four_words: assert property (burst_req && bcode == 3'h1 && addr < 9'h1F0 |-> ##2
        (dvalid && !dlast)[*3] ##1 (dvalid && dlast)) else $error("burst length wrong");
    a_cont_end: assert property (burst_req && bcode == QT_BURST_CONT && addr == 9'h1FA
        |-> ##2 (dvalid && !dlast)[*5] ##1 (dvalid && dlast))
        else $error("continuous burst end wrong");
    a_busy_words: assert property (dvalid && !dlast |-> busy)
        else $error("busy dropped inside burst");
endmodule // qtab_properties

// ---- test/qtab_tb.sv ----
// Self-checking bench: host and device ends joined over the query link
`timescale 1ns/10ps
module qtab_tb;
    import qtab_pkg::*;
    logic             clk, rst_b, disc_start, disc_done, page_ok, burst_ok;
    logic             rcr_valid, single_part, rd_start, rd_burst, rd_valid, rd_last;
    logic [1:0]       sync_sel;
    logic [2:0]       rcr_burst;
    logic [7:0]       page_code, data_width, part_count;
    logic [QT_AW-1:0] rd_addr;
    logic [QT_DW-1:0] rd_data;
    int               miscompares;
    int               num_checks;
    int               sync_code [4] = '{1, 2, 3, 7};

    qtab_if lnk ();
    qtab_dev u_qtab_dev (.clk(clk), .rst_b(rst_b), .lnk(lnk));
    qtab_host u_qtab_host (.clk(clk), .rst_b(rst_b), .lnk(lnk), .disc_start(disc_start),
        .sync_sel(sync_sel), .disc_done(disc_done), .page_ok(page_ok),
        .page_code(page_code), .data_width(data_width), .burst_ok(burst_ok),
        .rcr_burst(rcr_burst), .rcr_valid(rcr_valid), .single_part(single_part),
        .part_count(part_count), .rd_start(rd_start), .rd_addr(rd_addr),
        .rd_burst(rd_burst), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last));
    qtab_properties u_qtab_properties (.clk(clk), .rst_b(rst_b), .req(lnk.req),
        .addr(lnk.addr), .burst(lnk.burst), .bcode(lnk.bcode), .busy(lnk.busy),
        .dvalid(lnk.dvalid), .data(lnk.data), .dlast(lnk.dlast));

    // Expected table content, every unlisted location reads as zero
    function automatic logic [15:0] model_word(input int a);
        case (a)
            'h028: return 16'h0001;
            'h127: return 16'h0003;
            'h128: return 16'h0004;
            'h129: return 16'h0001;
            'h12A: return 16'h0002;
            'h12B: return 16'h0003;
            'h12C: return 16'h0007;
            'h12D: return 16'h0001;
            default: return 16'h0000;
        endcase
    endfunction

    // Bursts never run past the last location of the space
    function automatic int model_len(input int a, input int sel, input bit brst);
        int n;
        n = 1 << (sync_code[sel] + 1);
        if (!brst) return 1;
        if (sync_code[sel] == 7 || a + n > 512) return 512 - a;
        return n;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic discover();
        int i;
        int s;
        disc_start = 1'b1;
        step(1);
        disc_start = 1'b0;
        i = 0;
        while (disc_done !== 1'b1 && i < 300) begin
            step(1);
            i++;
        end
        chk(page_code, 16'h0003, "page code");
        chk(page_ok, 16'h0001, "page usable");
        chk(data_width, QT_WIDTH_X16, "word width");
        chk(burst_ok, 16'h0001, "burst usable");
        chk(part_count, QT_NPART, "region count");
        chk(single_part, 16'h0000, "single partition");
        for (s = 0; s < 4; s++) begin
            sync_sel = s[1:0];
            step(2);
            chk(rcr_burst, sync_code[s], "config burst code");
            chk(rcr_valid, 16'h0001, "config applicable");
        end
    endtask

    task automatic rd(input int a, input int sel, input bit brst);
        int          got;
        int          i;
        int          n;
        logic [15:0] exp_q [$];
        got = 0;
        n = model_len(a, sel, brst);
        for (i = 0; i < n; i++) exp_q.push_back(model_word(a + i));
        sync_sel = sel[1:0];
        step(2);
        rd_addr = a[8:0];
        rd_burst = brst;
        rd_start = 1'b1;
        step(1);
        rd_start = 1'b0;
        for (i = 0; i < 700; i++) begin
            if (rd_valid === 1'b1) begin
                if (exp_q.size() != 0) chk(rd_data, exp_q.pop_front(), "read word");
                got++;
                if (rd_last === 1'b1) break;
            end
            step(1);
        end
        chk(got[15:0], n[15:0], "word count");
        step(2);
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #(30000 * 8);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        int k;
        {rst_b, disc_start, rd_start, rd_burst, sync_sel, rd_addr} = '0;
        miscompares = 0;
        num_checks = 0;
        void'($urandom(32'h3a5d_276e));
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        step(1);
        discover();
        $display("test discovery done");
        for (k = 'h127; k <= 'h12D; k++) rd(k, 0, 0);
        rd('h028, 0, 0);
        for (k = 0; k < 6; k++) rd($urandom % 512, k % 4, 0);
        $display("test single reads done");
        for (k = 0; k < 3; k++) rd($urandom % 496, k, 1);
        rd('h1FD, 2, 1);
        rd('h1FA, 3, 1);
        rd('h100, 3, 1);
        $display("test bursts done");
        // Table must be unchanged after all the reads above
        discover();
        $display("test rediscovery done");
        conclude();
    end
endmodule // qtab_tb
